// ### mia_indirect_regs.sv
// Indirect access control, address/data window and extended status registers.
// Behaviour
// - Control bits 15:14 select mode; 00 address, 01 data without increment.
// - Mode 10: data access, address advances after every read and write.
// - Mode 11: data access, address advances after writes only.
// - Control bits 4:0 hold a read/write device address, reset zero.
// - In mode 00 the address/data register writes and reads the target address.
// - In other modes the address/data register reads/writes the selected register data.
// - Extended status bits 15 and 14 read zero.
// - Extended status bits 13 and 12 read one.
`timescale 1ns/1ps
`default_nettype none
module mia_indirect_regs (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic [4:0] mmdDevAddr,
    output logic [15:0] mmdRegAddr,
    output logic mmdWrEn,
    output logic mmdRdEn,
    output logic [15:0] mmdWrData,
    input wire logic [15:0] mmdRdData
);
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] regPtr_q, regPtr_d;
    logic [15:0] rdData_q, rdData_d;
    logic [1:0] opMode;
    logic dataMode;
    logic hitCtrl, hitData, hitStat;

    // The pointer wraps from ffff to 0000, so a long burst simply runs round the register space.
    function automatic logic [15:0] nextPtr(input logic [15:0] ptr);
        return ptr + 16'h0001;
    endfunction

    // Mode 10 advances after reads and writes; mode 11 after writes only.
    function automatic logic advanceOnWrite(input logic [1:0] mode);
        return (mode == mia_pkg::OP_DATA_INC_RW) || (mode == mia_pkg::OP_DATA_INC_WR);
    endfunction

    function automatic logic advanceOnRead(input logic [1:0] mode);
        return (mode == mia_pkg::OP_DATA_INC_RW);
    endfunction

    assign opMode = ctrl_q[mia_pkg::OP_HI:mia_pkg::OP_LO];
    assign dataMode = (opMode != mia_pkg::OP_ADDRESS);
    assign hitCtrl = (regAddr == mia_pkg::ADDR_CTRL);
    assign hitData = (regAddr == mia_pkg::ADDR_DATA);
    assign hitStat = (regAddr == mia_pkg::ADDR_EXTSTAT);

    assign mmdDevAddr = ctrl_q[mia_pkg::DEV_HI:mia_pkg::DEV_LO];
    assign mmdRegAddr = regPtr_q;
    // Data accesses pass straight through to the selected device in the same cycle.
    assign mmdWrEn = regWrEn && hitData && dataMode;
    assign mmdRdEn = regRdEn && hitData && dataMode;
    assign mmdWrData = regWrData;
    assign regRdData = rdData_q;

    always_comb begin
        ctrl_d = ctrl_q;
        regPtr_d = regPtr_q;
        rdData_d = rdData_q;
        if (regWrEn && hitCtrl) begin
            ctrl_d = regWrData;
        end
        if (regWrEn && hitData) begin
            if (!dataMode) begin
                regPtr_d = regWrData;
            end else if (advanceOnWrite(opMode)) begin
                regPtr_d = nextPtr(regPtr_q);
            end
        end
        if (regRdEn) begin
            if (hitCtrl) begin
                rdData_d = ctrl_q;
            end else if (hitData) begin
                rdData_d = dataMode ? mmdRdData : regPtr_q;
                // Reads advance only in mode 10; mode 11 leaves the pointer alone.
                if (advanceOnRead(opMode)) begin
                    regPtr_d = nextPtr(regPtr_q);
                end
            end else if (hitStat) begin
                rdData_d = mia_pkg::EXTSTAT_VALUE;
            end else begin
                rdData_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrl_q <= mia_pkg::CTRL_RESET;
            regPtr_q <= mia_pkg::ADDR_RESET;
            rdData_q <= 16'h0000;
        end else begin
            ctrl_q <= ctrl_d;
            regPtr_q <= regPtr_d;
            rdData_q <= rdData_d;
        end
    end

    property p_ctrl_reset;
        @(posedge core_clk) $rose(resetn) |-> (opMode == 2'h0 && mmdDevAddr == 5'h00);
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not reset");

    property p_inc_rw_read;
        @(posedge core_clk) disable iff (!resetn)
        (regRdEn && !regWrEn && hitData && opMode == 2'h2) |=> (regPtr_q == $past(regPtr_q) + 16'h0001);
    endproperty
    a_inc_rw_read: assert property (p_inc_rw_read) else $error("mode 10 read did not advance");

    property p_inc_wr_read;
        @(posedge core_clk) disable iff (!resetn)
        (regRdEn && !regWrEn && hitData && opMode == 2'h3) |=> (regPtr_q == $past(regPtr_q));
    endproperty
    a_inc_wr_read: assert property (p_inc_wr_read) else $error("mode 11 read moved pointer");

    property p_inc_wr_write;
        @(posedge core_clk) disable iff (!resetn)
        (regWrEn && !regRdEn && hitData && opMode == 2'h3) |=> (regPtr_q == $past(regPtr_q) + 16'h0001);
    endproperty
    a_inc_wr_write: assert property (p_inc_wr_write) else $error("mode 11 write did not advance");

    property p_noinc;
        @(posedge core_clk) disable iff (!resetn)
        (hitData && opMode == 2'h1) |=> (regPtr_q == $past(regPtr_q));
    endproperty
    a_noinc: assert property (p_noinc) else $error("mode 01 moved pointer");

    property p_dev_write;
        @(posedge core_clk) disable iff (!resetn)
        (regWrEn && hitCtrl) |=> (mmdDevAddr == $past(regWrData[4:0]));
    endproperty
    a_dev_write: assert property (p_dev_write) else $error("device address not stored");

    property p_addr_mode;
        @(posedge core_clk) disable iff (!resetn)
        (regWrEn && hitData && opMode == 2'h0) |=> (regPtr_q == $past(regWrData)) && !$past(mmdWrEn);
    endproperty
    a_addr_mode: assert property (p_addr_mode) else $error("address mode write wrong");

    property p_data_read;
        @(posedge core_clk) disable iff (!resetn)
        (regRdEn && hitData && opMode != 2'h0) |=> (regRdData == $past(mmdRdData));
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read not forwarded");

    property p_extstat;
        @(posedge core_clk) disable iff (!resetn)
        (regRdEn && hitStat) |=> (regRdData[15:12] == 4'h3 && regRdData[11:0] == 12'h000);
    endproperty
    a_extstat: assert property (p_extstat) else $error("extended status wrong");

    // Checks below are held off while reset is low; the release checks watch the release edge itself.
    property p_inc_rw_write;
        @(posedge core_clk) disable iff (!resetn)
        (regWrEn && !regRdEn && hitData && opMode == mia_pkg::OP_DATA_INC_RW)
            |=> (regPtr_q == $past(regPtr_q) + 16'h0001);
    endproperty
    a_inc_rw_write: assert property (p_inc_rw_write) else $error("mode 10 write did not advance");

    property p_addr_read;
        @(posedge core_clk) disable iff (!resetn)
        (regRdEn && !regWrEn && hitData && opMode == mia_pkg::OP_ADDRESS)
            |=> (regRdData == $past(regPtr_q)) && !$past(mmdRdEn);
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("address mode read wrong");

    property p_ctrl_read;
        @(posedge core_clk) disable iff (!resetn)
        (regRdEn && !regWrEn && hitCtrl) |=> (regRdData == $past(ctrl_q));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_data_write;
        @(posedge core_clk) disable iff (!resetn)
        (regWrEn && !regRdEn && hitData && opMode != mia_pkg::OP_ADDRESS)
            |-> (mmdWrEn && !mmdRdEn && mmdWrData == regWrData);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write not forwarded");

    property p_data_rd_strobe;
        @(posedge core_clk) disable iff (!resetn)
        (regRdEn && !regWrEn && hitData && opMode != mia_pkg::OP_ADDRESS) |-> (mmdRdEn && !mmdWrEn);
    endproperty
    a_data_rd_strobe: assert property (p_data_rd_strobe) else $error("data read strobe missing");

    property p_strobe_quiet;
        @(posedge core_clk) disable iff (!resetn)
        (!hitData || opMode == mia_pkg::OP_ADDRESS) |-> (!mmdWrEn && !mmdRdEn);
    endproperty
    a_strobe_quiet: assert property (p_strobe_quiet) else $error("stray device strobe");

    property p_stat_readonly;
        @(posedge core_clk) disable iff (!resetn)
        (regWrEn && hitStat) |=> (ctrl_q == $past(ctrl_q) && regPtr_q == $past(regPtr_q));
    endproperty
    a_stat_readonly: assert property (p_stat_readonly) else $error("status write changed state");

    // Read data stands until the next read, so a slow master may pick it up late.
    property p_rd_hold;
        @(posedge core_clk) disable iff (!resetn)
        !regRdEn |=> $stable(regRdData);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");

    property p_ptr_reset;
        @(posedge core_clk) $rose(resetn) |-> (mmdRegAddr == mia_pkg::ADDR_RESET && regRdData == 16'h0000);
    endproperty
    a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not reset");

    property p_dev_hold;
        @(posedge core_clk) disable iff (!resetn)
        !(regWrEn && hitCtrl) |=> $stable(mmdDevAddr) && $stable(opMode);
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("control changed without a write");

    property p_ptr_hold;
        @(posedge core_clk) disable iff (!resetn)
        !((regWrEn || regRdEn) && hitData) |=> $stable(regPtr_q);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without a window access");

    property p_mode_write;
        @(posedge core_clk) disable iff (!resetn)
        (regWrEn && hitCtrl) |=> (opMode == $past(regWrData[mia_pkg::OP_HI:mia_pkg::OP_LO]));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("operation mode not stored");
endmodule // mia_indirect_regs
`default_nettype wire

// ### mia_pkg.sv
// Constants for the indirect manageable-device register window.
package mia_pkg;
    localparam logic [4:0] ADDR_CTRL = 5'h0d;
    localparam logic [4:0] ADDR_DATA = 5'h0e;
    localparam logic [4:0] ADDR_EXTSTAT = 5'h0f;
    localparam int OP_HI = 15;
    localparam int OP_LO = 14;
    localparam int DEV_HI = 4;
    localparam int DEV_LO = 0;
    localparam int RSV_HI = 13;
    localparam int RSV_LO = 5;
    localparam logic [1:0] OP_ADDRESS = 2'h0;
    localparam logic [1:0] OP_DATA_NOINC = 2'h1;
    localparam logic [1:0] OP_DATA_INC_RW = 2'h2;
    localparam logic [1:0] OP_DATA_INC_WR = 2'h3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] EXTSTAT_VALUE = 16'h3000;
endpackage

// ### mia_mmd_model.sv
// Store of manageable-device registers behind the window.
`timescale 1ns/1ps
`default_nettype none
module mia_mmd_model (
    input wire logic core_clk,
    input wire logic wrEn,
    input wire logic [4:0] devAddr,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] wrData,
    output logic [15:0] rdData
);
    logic [15:0] mem [16];
    // The device number is mixed in so that a wrong device selection shows in the read data.
    assign rdData = mem[regAddr[3:0]] ^ {11'h000, devAddr};
    always_ff @(posedge core_clk) begin
        if (wrEn) mem[regAddr[3:0]] <= wrData;
    end
endmodule // mia_mmd_model
`default_nettype wire

// ### tb_mia_indirect_regs.sv
// Self-checking bench for the indirect register window.
`timescale 1ns/1ps
`default_nettype none
module tb_mia_indirect_regs;
    logic core_clk = 0, resetn = 0, regWrEn = 0, regRdEn = 0, rdSeen = 0, mmdWrEn, mmdRdEn;
    logic [4:0] regAddr = 5'h00, mmdDevAddr;
    logic [15:0] regWrData = 16'h0000, regRdData, mmdRegAddr, mmdWrData, mmdRdData, p, d;
    logic [15:0] sh [16];
    logic [15:0] expQ [$];
    logic [1:0] curMode = mia_pkg::OP_ADDRESS;
    int n_fail = 0, checked = 0;
    always #5 core_clk = ~core_clk;
    mia_indirect_regs DUT (.core_clk(core_clk), .resetn(resetn), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .mmdDevAddr(mmdDevAddr),
        .mmdRegAddr(mmdRegAddr), .mmdWrEn(mmdWrEn), .mmdRdEn(mmdRdEn), .mmdWrData(mmdWrData), .mmdRdData(mmdRdData));
    mia_mmd_model partner (.core_clk(core_clk), .wrEn(mmdWrEn), .devAddr(mmdDevAddr), .regAddr(mmdRegAddr),
        .wrData(mmdWrData), .rdData(mmdRdData));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // A read strobe notes its expected word; the monitor below compares it a cycle later.
    task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] v);
        logic fwd;
        fwd = (a == mia_pkg::ADDR_DATA) && (curMode != mia_pkg::OP_ADDRESS);
        if (!wr) expQ.push_back(v);
        @(posedge core_clk);
        regWrEn <= wr;
        regRdEn <= !wr;
        regAddr <= a;
        regWrData <= v;
        // Device strobes are combinational, so they are looked at mid-cycle while the request stands.
        @(negedge core_clk);
        chk("mmdWrEn", {15'h0000, mmdWrEn}, {15'h0000, wr && fwd});
        chk("mmdRdEn", {15'h0000, mmdRdEn}, {15'h0000, !wr && fwd});
        if (wr && fwd) chk("mmdWrData", mmdWrData, v);
        @(posedge core_clk);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        if (wr && a == mia_pkg::ADDR_CTRL) curMode = v[mia_pkg::OP_HI:mia_pkg::OP_LO];
    endtask
    task automatic setp(input logic [1:0] m);
        p = 16'hffff;
        acc(1, mia_pkg::ADDR_CTRL, 16'h0005);
        acc(1, mia_pkg::ADDR_DATA, p);
        acc(0, mia_pkg::ADDR_DATA, p);
        acc(1, mia_pkg::ADDR_CTRL, {m, 14'h0005});
        acc(0, mia_pkg::ADDR_CTRL, {m, 14'h0005});
        chk("mmdDevAddr", {11'h000, mmdDevAddr}, 16'h0005);
    endtask
    always @(posedge core_clk) rdSeen <= regRdEn;
    always @(negedge core_clk) begin
        if (rdSeen) chk("regRdData", regRdData, expQ.size() > 0 ? expQ.pop_front() : 16'hxxxx);
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h0620));
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        acc(0, mia_pkg::ADDR_CTRL, 16'h0000);
        acc(0, mia_pkg::ADDR_DATA, 16'h0000);
        acc(1, mia_pkg::ADDR_EXTSTAT, 16'hffff);
        acc(0, mia_pkg::ADDR_EXTSTAT, 16'h3000);
        acc(0, 5'h10, 16'h0000);
        for (int m = 1; m < 4; m++) begin
            setp(m[1:0]);
            repeat (2) begin
                d = 16'($urandom);
                acc(1, mia_pkg::ADDR_DATA, d);
                sh[p[3:0]] = d;
                if (m > 1) p++;
                #1 chk("mmdRegAddr", mmdRegAddr, p);
            end
            setp(m[1:0]);
            repeat (2) begin
                acc(0, mia_pkg::ADDR_DATA, sh[p[3:0]] ^ 16'h0005);
                if (m == 2) p++;
                #1 chk("mmdRegAddr", mmdRegAddr, p);
            end
        end
        // A second reset in mid-run must bring the window back to address mode with a zero pointer.
        @(posedge core_clk);
        resetn <= 1'b0;
        curMode = mia_pkg::OP_ADDRESS;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        acc(0, mia_pkg::ADDR_CTRL, mia_pkg::CTRL_RESET);
        acc(0, mia_pkg::ADDR_DATA, mia_pkg::ADDR_RESET);
        repeat (2) @(posedge core_clk);
        tally_and_finish();
    end
endmodule // tb_mia_indirect_regs
`default_nettype wire
